//--- rtl/psc_cfg.svh
// Offsets, field positions, reset values and timing counts of the storm control block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// Register byte offsets
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_STATUS 8'h04
`define PSC_OFS_CMD 8'h08
`define PSC_OFS_TRAPCNT 8'h0C
`define PSC_OFS_RISE0 8'h10
`define PSC_OFS_FALL0 8'h20
`define PSC_ADDR_W 8

// Control fields, class c uses bit base + c
`define PSC_CTRL_EN_LSB 0
`define PSC_CTRL_PPS_LSB 3
`define PSC_CTRL_FEN_LSB 6
`define PSC_CTRL_SHUT_BIT 9
`define PSC_CTRL_TRAP_BIT 10
`define PSC_CTRL_W 11

// Status fields
`define PSC_STAT_STORM_LSB 0
`define PSC_STAT_ERRDIS_BIT 3

// Command fields
`define PSC_CMD_REEN_BIT 0

// Reset values
`define PSC_CTRL_RST 11'h000
`define PSC_RISE_RST 32'hFFFFFFFF
`define PSC_FALL_RST 32'h00000000

// Unlimited levels: hundredths of a percent, and packets per second
`define PSC_PCT_FULL 32'h00002710
`define PSC_PPS_FULL 32'hFFFFFFFF

// Timing: clock 200 MHz, measurement interval 1 ms
`define PSC_CLK_HZ 200000000
`define PSC_INTERVAL_US 1000
`define PSC_INTERVAL_CYC ((`PSC_CLK_HZ / 1000000) * `PSC_INTERVAL_US)
`define PSC_INTERVALS_PER_S (1000000 / `PSC_INTERVAL_US)
// Bytes one gigabit link carries in one interval
`define PSC_LINK_BPS 1000000000
`define PSC_BYTES_PER_INTERVAL ((`PSC_LINK_BPS / 8 / 1000000) * `PSC_INTERVAL_US)

`endif

//--- rtl/psc_meter.sv
// Rate meter and storm detector for one traffic class
`timescale 1ns/1ps
`include "psc_cfg.svh"

module psc_meter #(
    parameter int unsigned CNT_W = 32,
    parameter logic [31:0] BYTES_PER_INTERVAL = 32'(`PSC_BYTES_PER_INTERVAL),
    parameter logic [31:0] INTERVALS_PER_S = 32'(`PSC_INTERVALS_PER_S)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic hit,
    input wire logic [13:0] len,
    input wire psc_pkg::psc_mcfg_t cfg,
    output logic storm,
    output logic storm_start
);

    logic [CNT_W-1:0] byte_cnt_r;
    logic [CNT_W-1:0] pkt_cnt_r;
    logic [CNT_W-1:0] byte_add;
    logic [63:0] rate;
    logic [63:0] rise_lim;
    logic [63:0] fall_lim;
    logic limited;
    logic over_rise;
    logic under_exit;
    psc_pkg::psc_mstate_t state_r;
    psc_pkg::psc_mstate_t state_nxt;

    assign byte_add = CNT_W'(len);

    // Received counts of the running interval, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_cnt_r <= '0;
            pkt_cnt_r <= '0;
        end else if (tick) begin
            byte_cnt_r <= hit ? byte_add : '0;
            pkt_cnt_r <= hit ? CNT_W'(1) : '0;
        end else if (hit) begin
            byte_cnt_r <= (byte_cnt_r > ~byte_add) ? '1 : byte_cnt_r + byte_add;
            pkt_cnt_r <= (&pkt_cnt_r) ? pkt_cnt_r : pkt_cnt_r + CNT_W'(1);
        end
    end

    // Scale the rate, and in percentage mode the levels too, so that no division is needed
    always_comb begin
        if (cfg.pps) begin
            rate = 64'(pkt_cnt_r) * 64'(INTERVALS_PER_S);
            rise_lim = 64'(cfg.rise);
            fall_lim = 64'(cfg.fall);
            limited = cfg.rise < `PSC_PPS_FULL;
        end else begin
            rate = 64'(byte_cnt_r) * 64'(`PSC_PCT_FULL);
            rise_lim = 64'(cfg.rise) * 64'(BYTES_PER_INTERVAL);
            fall_lim = 64'(cfg.fall) * 64'(BYTES_PER_INTERVAL);
            limited = cfg.rise < `PSC_PCT_FULL;
        end
    end

    // Level reached means storm; exit below falling level if given
    assign over_rise = rate >= rise_lim;
    assign under_exit = cfg.fall_en ? (rate < fall_lim) : (rate < rise_lim);

    // Entry judged once per interval; exit too, except at once when the class is disabled or its rising level is unlimited
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            psc_pkg::PSC_QUIET: begin
                if (tick && cfg.en && limited && over_rise) begin
                    state_nxt = psc_pkg::PSC_STORM;
                end
            end
            psc_pkg::PSC_STORM: begin
                if (!cfg.en || !limited) begin
                    state_nxt = psc_pkg::PSC_QUIET;
                end else if (tick && under_exit) begin
                    state_nxt = psc_pkg::PSC_QUIET;
                end
            end
            default: state_nxt = psc_pkg::PSC_QUIET;
        endcase
    end

    // Storm state, off after reset until software enables the class
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= psc_pkg::PSC_QUIET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign storm = state_r == psc_pkg::PSC_STORM;
    assign storm_start = state_r == psc_pkg::PSC_QUIET && state_nxt == psc_pkg::PSC_STORM;

endmodule

//--- rtl/psc_pkg.sv
// Types shared by the storm control block
package psc_pkg;

    // Traffic class of a received frame
    typedef enum logic [1:0] {
        PSC_CLS_BC,
        PSC_CLS_MC,
        PSC_CLS_UC,
        PSC_CLS_NONE
    } psc_cls_t;

    // Descriptor of one received frame from the forwarding path
    typedef struct packed {
        psc_cls_t cls;
        logic stp;
        logic [13:0] len;
    } psc_frame_t;

    // Verdict returned for that frame
    typedef struct packed {
        logic valid;
        logic fwd;
        logic drop;
    } psc_verdict_t;

    // Per-class meter configuration
    typedef struct packed {
        logic en;
        logic pps;
        logic fall_en;
        logic [31:0] rise;
        logic [31:0] fall;
    } psc_mcfg_t;

    // Meter state
    typedef enum logic {
        PSC_QUIET,
        PSC_STORM
    } psc_mstate_t;

endpackage

//--- rtl/psc_top.sv
// Per-port storm control with AHB-Lite register access
// Operation
// - After reset suppression is off for broadcast, multicast and unicast until software enables a class.
// - With no action set, a storm is handled by filtering only and no trap is raised.
// - A percentage level of 100 places no limit on the class.
// - Percentage suppression acts only when the rising level is below 100, else no storm is declared.
// - A packet-rate level of 4294967295 places no limit on the class.
// - Packet-rate suppression acts only when the rising level is below 4294967295, else no storm is declared.
// - Without a falling level, filtering lasts until the rate drops below the rising level.
// - With a falling level, filtering lasts until the rate drops below the falling level.
// - A multicast or unicast storm drops all broadcast, multicast and unicast frames, passing only STP frames.
// - A broadcast storm drops only broadcast frames and keeps forwarding the rest.
// - Trap and shutdown actions are enabled separately and do not affect each other.
// - With shutdown enabled a storm error-disables the port until software re-enables it.
// - With trap enabled each cycle in which one or more classes enter a storm raises one management notification.
`timescale 1ns/1ps
`include "psc_cfg.svh"

module psc_top #(
    parameter int unsigned INTERVAL_CYC = `PSC_INTERVAL_CYC,
    parameter logic [31:0] BYTES_PER_INTERVAL = 32'(`PSC_BYTES_PER_INTERVAL),
    parameter logic [31:0] INTERVALS_PER_S = 32'(`PSC_INTERVALS_PER_S)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frm_valid,
    input wire psc_pkg::psc_frame_t frm_desc,
    output psc_pkg::psc_verdict_t frm_verdict,
    output logic port_err_disabled,
    output logic mgmt_trap
);

    localparam int CLS_N = 3;
    localparam int TICK_W = $clog2(INTERVAL_CYC + 1);

    logic [`PSC_CTRL_W-1:0] ctrl_r;
    logic [31:0] rise_r [CLS_N];
    logic [31:0] fall_r [CLS_N];
    logic [31:0] trap_cnt_r;
    logic err_dis_r;
    logic trap_r;
    psc_pkg::psc_verdict_t verdict_r;

    logic ap_wr_r;
    logic [`PSC_ADDR_W-1:0] ap_addr_r;
    logic [31:0] rdata_r;
    logic ap_take;
    logic [`PSC_ADDR_W-1:0] ap_addr;
    logic [31:0] rd_val;

    logic [TICK_W-1:0] tick_cnt_r;
    logic tick;
    logic [CLS_N-1:0] storm;
    logic [CLS_N-1:0] storm_start;
    logic any_start;
    logic reenable;
    logic shut_en;
    logic trap_en;

    // Bus answers at once and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    // Address phase taken on a selected NONSEQ or SEQ transfer
    assign ap_take = hsel && hready && htrans[1];
    assign ap_addr = haddr[`PSC_ADDR_W-1:0];

    // Write address held into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_addr_r <= '0;
        end else if (hready) begin
            ap_wr_r <= ap_take && hwrite;
            ap_addr_r <= ap_addr;
        end
    end

    // Read mux, unmapped offsets and unused bits read zero
    always_comb begin
        rd_val = 32'h00000000;
        case (ap_addr)
            `PSC_OFS_CTRL: rd_val = 32'(ctrl_r);
            `PSC_OFS_STATUS: begin
                rd_val[`PSC_STAT_STORM_LSB +: CLS_N] = storm;
                rd_val[`PSC_STAT_ERRDIS_BIT] = err_dis_r;
            end
            `PSC_OFS_TRAPCNT: rd_val = trap_cnt_r;
            default: begin
                for (int c = 0; c < CLS_N; c++) begin
                    if (ap_addr == `PSC_OFS_RISE0 + 8'(4 * c)) begin
                        rd_val = rise_r[c];
                    end
                    if (ap_addr == `PSC_OFS_FALL0 + 8'(4 * c)) begin
                        rd_val = fall_r[c];
                    end
                end
            end
        endcase
    end

    // Read data captured at the address phase, stands for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            rdata_r <= rd_val;
        end
    end

    // Control word: class enables, rate modes, falling enables, actions
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `PSC_CTRL_RST;
        end else if (ap_wr_r && ap_addr_r == `PSC_OFS_CTRL) begin
            ctrl_r <= hwdata[`PSC_CTRL_W-1:0];
        end
    end

    // Rising and falling levels per class
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < CLS_N; c++) begin
                rise_r[c] <= `PSC_RISE_RST;
                fall_r[c] <= `PSC_FALL_RST;
            end
        end else if (ap_wr_r) begin
            for (int c = 0; c < CLS_N; c++) begin
                if (ap_addr_r == `PSC_OFS_RISE0 + 8'(4 * c)) begin
                    rise_r[c] <= hwdata;
                end
                if (ap_addr_r == `PSC_OFS_FALL0 + 8'(4 * c)) begin
                    fall_r[c] <= hwdata;
                end
            end
        end
    end

    // Re-enable command is a write-only strobe
    assign reenable = ap_wr_r && ap_addr_r == `PSC_OFS_CMD && hwdata[`PSC_CMD_REEN_BIT];

    assign shut_en = ctrl_r[`PSC_CTRL_SHUT_BIT];
    assign trap_en = ctrl_r[`PSC_CTRL_TRAP_BIT];

    // Interval divider, one-cycle tick ends every interval
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
        end
    end

    assign tick = tick_cnt_r == TICK_W'(INTERVAL_CYC - 1);

    // One meter per class; received frames count even if dropped
    generate
        for (genvar c = 0; c < CLS_N; c++) begin : g_meter
            psc_pkg::psc_mcfg_t mcfg;
            logic hit;

            assign hit = frm_valid && frm_desc.cls == psc_pkg::psc_cls_t'(c);
            assign mcfg.en = ctrl_r[`PSC_CTRL_EN_LSB + c];
            assign mcfg.pps = ctrl_r[`PSC_CTRL_PPS_LSB + c];
            assign mcfg.fall_en = ctrl_r[`PSC_CTRL_FEN_LSB + c];
            assign mcfg.rise = rise_r[c];
            assign mcfg.fall = fall_r[c];

            psc_meter #(
                .CNT_W(32),
                .BYTES_PER_INTERVAL(BYTES_PER_INTERVAL),
                .INTERVALS_PER_S(INTERVALS_PER_S)
            ) u_meter (
                .hclk(hclk),
                .hresetn(hresetn),
                .tick(tick),
                .hit(hit),
                .len(frm_desc.len),
                .cfg(mcfg),
                .storm(storm[c]),
                .storm_start(storm_start[c])
            );
        end
    endgenerate

    assign any_start = |storm_start;

    // Error-disable; a new storm wins over a same-cycle re-enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_dis_r <= 1'b0;
        end else if (any_start && shut_en) begin
            err_dis_r <= 1'b1;
        end else if (reenable) begin
            err_dis_r <= 1'b0;
        end
    end

    assign port_err_disabled = err_dis_r;

    // Trap pulse and running count, independent of shutdown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_r <= 1'b0;
            trap_cnt_r <= 32'h00000000;
        end else begin
            trap_r <= any_start && trap_en;
            if (any_start && trap_en && trap_cnt_r != 32'hFFFFFFFF) begin
                trap_cnt_r <= trap_cnt_r + 32'h00000001;
            end
        end
    end

    assign mgmt_trap = trap_r;

    // Verdict one cycle after the frame; filtering is the base action
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            verdict_r <= '0;
        end else begin
            verdict_r.valid <= frm_valid;
            verdict_r.fwd <= 1'b0;
            verdict_r.drop <= 1'b0;
            if (frm_valid) begin
                if (err_dis_r) begin
                    verdict_r.drop <= 1'b1;
                end else if (storm[psc_pkg::PSC_CLS_MC] || storm[psc_pkg::PSC_CLS_UC]) begin
                    verdict_r.fwd <= frm_desc.stp;
                    verdict_r.drop <= !frm_desc.stp;
                end else if (storm[psc_pkg::PSC_CLS_BC] && frm_desc.cls == psc_pkg::PSC_CLS_BC) begin
                    verdict_r.drop <= !frm_desc.stp;
                    verdict_r.fwd <= frm_desc.stp;
                end else begin
                    verdict_r.fwd <= 1'b1;
                end
            end
        end
    end

    assign frm_verdict = verdict_r;

endmodule

//--- verif/psc_fwd_model.sv
// Forwarding path model: frame descriptors in, verdicts back
`timescale 1ns/1ps
module psc_fwd_model (
    input wire logic hclk,
    output logic frm_valid,
    output psc_pkg::psc_frame_t frm_desc,
    input wire psc_pkg::psc_verdict_t frm_verdict
);
    logic [16:0] d = 17'h00000;
    // Idle descriptor toggles so a stale value never looks valid
    initial begin
        frm_valid = 1'b0;
        frm_desc = '0;
    end
    // One frame, verdict taken in the cycle it stands
    task automatic send(input logic [1:0] c, input logic s, output psc_pkg::psc_verdict_t v);
        @(posedge hclk);
        d = {c, s, 14'h0040};
        frm_valid <= 1'b1;
        frm_desc <= psc_pkg::psc_frame_t'(d);
        @(posedge hclk);
        d = ~d;
        frm_valid <= 1'b0;
        frm_desc <= psc_pkg::psc_frame_t'(d);
        #1 v = frm_verdict;
    endtask
    // Frames of 100 bytes every gap cycles, back to back at gap 1
    task automatic stream(input logic [1:0] c, input int gap, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            d = (i % gap == 0) ? {c, 1'b0, 14'h0064} : ~d;
            frm_valid <= (i % gap == 0);
            frm_desc <= psc_pkg::psc_frame_t'(d);
        end
        @(posedge hclk);
        frm_valid <= 1'b0;
    endtask
endmodule

//--- verif/psc_sva.sv
// Port assertions for the storm control block
`timescale 1ns/1ps
module psc_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic frm_valid,
    input wire psc_pkg::psc_verdict_t frm_verdict,
    input wire logic port_err_disabled,
    input wire logic mgmt_trap
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic tk;
    logic cmd_rd;
    logic cmd_wr_r;
    // Address phases taken by the slave
    assign tk = hsel && hready && htrans[1];
    assign cmd_rd = tk && !hwrite && haddr[7:0] == 8'h08;
    // Command write remembered into its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cmd_wr_r <= 1'b0;
        else
            cmd_wr_r <= tk && hwrite && haddr[7:0] == 8'h08;
    end
    verdict_pulse_a: assert property (frm_valid |=> frm_verdict.valid) else $error("verdict missing");
    verdict_quiet_a: assert property (!frm_valid |=> !frm_verdict.valid) else $error("stray verdict");
    verdict_one_a: assert property (frm_verdict.valid |-> frm_verdict.fwd != frm_verdict.drop)
        else $error("verdict not one of two");
    errdis_drop_a: assert property (port_err_disabled && frm_valid |=> frm_verdict.drop)
        else $error("frame passed while disabled");
    errdis_hold_a: assert property ($fell(port_err_disabled) |-> $past(cmd_wr_r) && $past(hwdata[0]))
        else $error("port left disabled state alone");
    trap_pulse_a: assert property (mgmt_trap |=> !mgmt_trap) else $error("trap longer than one cycle");
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    cmd_read_a: assert property (cmd_rd |=> hrdata == 32'h00000000) else $error("command word read back");
endmodule

bind psc_top psc_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frm_valid(frm_valid), .frm_verdict(frm_verdict), .port_err_disabled(port_err_disabled),
    .mgmt_trap(mgmt_trap));

//--- verif/psc_top_tb_top.sv
// Self-checking bench for the storm control block
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_top_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic frm_valid;
    psc_pkg::psc_frame_t frm_desc;
    psc_pkg::psc_verdict_t frm_verdict;
    logic port_err_disabled;
    logic mgmt_trap;
    int n_fail = 0;
    int cmp_count = 0;
    int n_trap = 0;
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;
    // Trap pulses counted in the cycle they stand
    always @(posedge hclk) if (mgmt_trap === 1'b1) n_trap++;
    // Short 100-cycle interval, byte scale cut to 1000 per interval, packet scale left at its default of 1000
    psc_top #(.INTERVAL_CYC(32'h00000064), .BYTES_PER_INTERVAL(32'h000003E8), .INTERVALS_PER_S(32'h000003E8)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .frm_valid(frm_valid), .frm_desc(frm_desc), .frm_verdict(frm_verdict),
        .port_err_disabled(port_err_disabled), .mgmt_trap(mgmt_trap));
    psc_fwd_model fwd (.hclk(hclk), .frm_valid(frm_valid), .frm_desc(frm_desc), .frm_verdict(frm_verdict));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Address phase held until ready, then data phase until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~{24'h000000, a};
        hwdata <= w ? wd : ~wd;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    task automatic probe(input logic [1:0] c, input logic s, input logic f);
        psc_pkg::psc_verdict_t v;
        fwd.send(c, s, v);
        chk($sformatf("verdict cls %0d stp %0d", c, s), 32'(v), {29'h00000000, 1'b1, f, ~f});
    endtask
    // Defaults, unmapped read, traffic passes untouched
    task automatic t_reset;
        rd(`PSC_OFS_CTRL, 32'h00000000);
        rd(`PSC_OFS_RISE0, 32'hFFFFFFFF);
        rd(`PSC_OFS_FALL0, 32'h00000000);
        rd(`PSC_OFS_TRAPCNT, 32'h00000000);
        rd(8'h30, 32'h00000000);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000000);
        probe(2'h0, 1'b0, 1'b1);
    endtask
    // Unlimited levels in both modes against finite ones
    task automatic t_limits;
        wr(`PSC_OFS_CTRL, 32'h00000001);
        wr(`PSC_OFS_RISE0, 32'h00002710);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000000);
        wr(`PSC_OFS_RISE0, 32'h00001388);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
        wr(`PSC_OFS_CTRL, 32'h00000009);
        wr(`PSC_OFS_RISE0, 32'hFFFFFFFF);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000000);
        wr(`PSC_OFS_RISE0, 32'h0000C350);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
    endtask
    // Exit at the rising level, then at the falling level
    task automatic t_hyst;
        fwd.stream(2'h0, 4, 250);
        rd(`PSC_OFS_STATUS, 32'h00000000);
        wr(`PSC_OFS_CTRL, 32'h00000049);
        wr(`PSC_OFS_FALL0, 32'h00002710);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
        fwd.stream(2'h0, 4, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
        fwd.stream(2'h0, 20, 250);
        rd(`PSC_OFS_STATUS, 32'h00000000);
        // Percent hysteresis: 60 in, 40 out, half rate sits between
        wr(`PSC_OFS_CTRL, 32'h00000041);
        wr(`PSC_OFS_RISE0, 32'h00001770);
        wr(`PSC_OFS_FALL0, 32'h00000FA0);
        fwd.stream(2'h0, 1, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
        fwd.stream(2'h0, 20, 250);
        rd(`PSC_OFS_STATUS, 32'h00000001);
        repeat (250) @(posedge hclk);
        rd(`PSC_OFS_STATUS, 32'h00000000);
    endtask
    // Level 0 keeps a storm up so verdicts can be probed at leisure
    task automatic t_filter;
        wr(`PSC_OFS_CTRL, 32'h00000009);
        wr(`PSC_OFS_RISE0, 32'h00000000);
        repeat (250) @(posedge hclk);
        probe(2'h0, 1'b0, 1'b0);
        probe(2'h0, 1'b1, 1'b1);
        probe(2'h1, 1'b0, 1'b1);
        probe(2'h2, 1'b0, 1'b1);
        wr(`PSC_OFS_CTRL, 32'h00000002);
        wr(`PSC_OFS_RISE0 + 8'h04, 32'h00000000);
        repeat (250) @(posedge hclk);
        rd(`PSC_OFS_STATUS, 32'h00000002);
        probe(2'h0, 1'b0, 1'b0);
        probe(2'h1, 1'b0, 1'b0);
        probe(2'h2, 1'b0, 1'b0);
        probe(2'h1, 1'b1, 1'b1);
        // Unicast storm in packet-rate mode blocks broadcast too
        wr(`PSC_OFS_CTRL, 32'h00000024);
        wr(`PSC_OFS_RISE0 + 8'h08, 32'h00000000);
        repeat (250) @(posedge hclk);
        rd(`PSC_OFS_STATUS, 32'h00000004);
        probe(2'h0, 1'b0, 1'b0);
        probe(2'h2, 1'b1, 1'b1);
        chk("trap pulses", n_trap, 0);
        rd(`PSC_OFS_TRAPCNT, 32'h00000000);
    endtask
    // Trap alone, then shutdown alone, then software re-enable
    task automatic t_actions;
        wr(`PSC_OFS_CTRL, 32'h00000000);
        wr(`PSC_OFS_CTRL, 32'h00000402);
        repeat (250) @(posedge hclk);
        chk("trap pulses", n_trap, 1);
        rd(`PSC_OFS_TRAPCNT, 32'h00000001);
        chk("err disabled", port_err_disabled, 0);
        wr(`PSC_OFS_CTRL, 32'h00000000);
        wr(`PSC_OFS_CTRL, 32'h00000202);
        repeat (500) @(posedge hclk);
        chk("err disabled", port_err_disabled, 1);
        chk("trap pulses", n_trap, 1);
        probe(2'h1, 1'b1, 1'b0);
        rd(`PSC_OFS_STATUS, 32'h0000000A);
        wr(`PSC_OFS_CMD, 32'h00000001);
        rd(`PSC_OFS_CMD, 32'h00000000);
        rd(`PSC_OFS_STATUS, 32'h00000002);
        probe(2'h1, 1'b1, 1'b1);
    endtask
    // Reset for 3 cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_limits;
        t_hyst;
        t_filter;
        t_actions;
        tally_and_finish;
    end
    // Watchdog, about four times the expected run
    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
endmodule
